// ### rtl/aoas_pkg.sv
/*
  Constants shared by the analog output alarm and status block.
  Assumes a single 40 MHz clock domain.
*/
package aoas_pkg;

  // --------------------------------------------------------------------
  // Word addressing
  // --------------------------------------------------------------------
  localparam int unsigned BASE_WORD      = 2000;
  localparam int unsigned WORDS_PER_UNIT = 10;
  localparam logic [3:0]  STATUS_OFFSET  = 4'h9;
  localparam logic [6:0]  UNIT_NUM_MAX   = 7'h5f;

  // --------------------------------------------------------------------
  // Status word field positions
  // --------------------------------------------------------------------
  localparam int unsigned SET_ERR_LSB    = 0;
  localparam int unsigned SET_ERR_WIDTH  = 8;
  localparam int unsigned BIT_HOLD_ERR   = 10;
  localparam int unsigned BIT_OUTNUM_ERR = 13;
  localparam int unsigned BIT_NVM_ERR    = 14;
  localparam int unsigned BIT_ADJ_MODE   = 15;
  localparam logic [15:0] STATUS_RESET   = 16'h0000;

  // --------------------------------------------------------------------
  // Codes
  // --------------------------------------------------------------------
  localparam logic [15:0] HOLD_CODE_MAX  = 16'h0002;
  localparam logic [7:0]  ADJ_OUT_MIN    = 8'h11;
  localparam logic [7:0]  ADJ_OUT_MAX    = 8'h14;

  // --------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 40_000_000;
  localparam int unsigned FLASH_MS       = 250;
  localparam int unsigned FLASH_CYCLES   = CLK_HZ / 1000 * FLASH_MS;

  // What each analog output shows
  typedef enum logic [1:0] {
    AOAS_OUT_LIVE,
    AOAS_OUT_ZERO,
    AOAS_OUT_HOLD_FN,
    AOAS_OUT_KEEP
  } aoas_out_sel_t;

endpackage

// ### rtl/aoas_out_store.sv
/*
  Storage for the analog output values with a registered read port.
  Assumes values are written one channel per cycle by the status block.
*/
`timescale 1ns/1ps
module aoas_out_store #(
  parameter int unsigned NUM_OUT = 8,
  parameter int unsigned WIDTH   = 16
) (
  input  wire logic                       clk_i,
  input  wire logic                       we_i,
  input  wire logic [$clog2(NUM_OUT)-1:0] waddr_i,
  input  wire logic [WIDTH-1:0]           wdata_i,
  input  wire logic [$clog2(NUM_OUT)-1:0] raddr_i,
  output logic      [WIDTH-1:0]           rdata_o
);

  logic [WIDTH-1:0] mem [NUM_OUT];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end

endmodule // aoas_out_store

// ### rtl/aoas_status.sv
/*
  Alarm, indicator and output-fault logic of an analog output unit.
  Assumes all inputs are synchronous to clk_i and that the host reads
  the status word through I/O refresh on status_word_o.
*/
// Summary of operation
// - Green operating lamp lit in normal operation, dark once exchange stops.
// - Unit error lamp lit on any alarm or bad initial setting.
// - Adjust lamp flashes in adjustment mode, dark otherwise.
// - Host error lamp lit on an error in host data exchange.
// - Alarm flags sit in bits 00 to 15 of status word at offset 9.
// - Base word address equals 2000 plus ten times unit number.
// - Out-of-range set value flags its bit; output takes hold value.
// - Four-output variant uses bits 00 to 03; bits 04 to 07 zero.
// - Normal operation alarms clear by themselves when cause goes away.
// - Memory write failure in adjustment sets bit 14, keeps outputs.
// - Bit 15 set whenever in adjustment mode, zero in normal mode.
// - Bad adjust output number sets bit 13, output forced to zero.
// - Host monitor or run in adjustment: only bit 15, outputs zero.
// - Bad stop hold code sets bit 10, unit lamp lit, run dark.
// - Initial setting flags clear only on restart after correction.
// - Bus watchdog fault: host and run lamps lit, outputs hold value.
// - Host response timeout keeps outputs at their previous values.
// - Bad or duplicate unit number: host lamp, run dark, outputs zero.
// - I/O table mismatch is a host setting error, host lamp lit.
// - During restart every output is driven to zero.
`timescale 1ns/1ps
module aoas_status #(
  parameter int unsigned NUM_OUT      = 8,
  parameter int unsigned WIDTH        = 16,
  parameter int unsigned FLASH_CYCLES = aoas_pkg::FLASH_CYCLES
) (
  input  wire logic                       clk_i,
  input  wire logic                       reset_i,
  input  wire logic [6:0]                 unit_number_i,
  input  wire logic                       unit_dup_i,
  input  wire logic                       table_mismatch_i,
  input  wire logic                       restart_i,
  input  wire logic                       exchange_ok_i,
  input  wire logic                       bus_error_i,
  input  wire logic                       host_watchdog_fault_i,
  input  wire logic                       host_timeout_i,
  input  wire logic                       host_run_i,
  input  wire logic                       four_out_i,
  input  wire logic                       adjust_mode_i,
  input  wire logic [7:0]                 adjust_out_num_i,
  input  wire logic [NUM_OUT-1:0]         out_enabled_i,
  input  wire logic                       nvm_fail_i,
  input  wire logic                       adjust_commit_i,
  input  wire logic [15:0]                hold_setting_i,
  input  wire logic [NUM_OUT-1:0]         set_range_err_i,
  input  wire logic [NUM_OUT*WIDTH-1:0]   set_value_i,
  input  wire logic [NUM_OUT*WIDTH-1:0]   hold_value_i,
  output logic                            run_indicator_o,
  output logic                            unit_error_indicator_o,
  output logic                            adjust_indicator_o,
  output logic                            host_error_indicator_o,
  output logic [15:0]                     status_word_o,
  output logic [15:0]                     base_word_o,
  output logic [NUM_OUT*WIDTH-1:0]        analog_out_o,
  output logic [WIDTH-1:0]                out_readback_o
);

  localparam int unsigned AW = $clog2(NUM_OUT);
  localparam int unsigned FW = $clog2(FLASH_CYCLES + 1);

  // --------------------------------------------------------------------
  // Decode helpers
  // --------------------------------------------------------------------
  function automatic logic adj_num_bad(input logic [7:0] num,
                                       input logic [NUM_OUT-1:0] en);
    logic [7:0] idx;
    idx = num - aoas_pkg::ADJ_OUT_MIN;
    if (num < aoas_pkg::ADJ_OUT_MIN || num > aoas_pkg::ADJ_OUT_MAX) begin
      adj_num_bad = 1'b1;
    end else begin
      adj_num_bad = (idx >= 8'(NUM_OUT)) ? 1'b1 : !en[idx[AW-1:0]];
    end
  endfunction

  function automatic logic [15:0] base_word(input logic [6:0] unit);
    base_word = 16'(aoas_pkg::BASE_WORD) +
                16'(unit) * 16'(aoas_pkg::WORDS_PER_UNIT);
  endfunction

  // Source of one channel, highest priority first
  function automatic aoas_pkg::aoas_out_sel_t out_source(
    input logic zero_now,
    input logic plc_err,
    input logic nvm_keep,
    input logic num_err,
    input logic timeout,
    input logic bus_fault,
    input logic set_bad
  );
    if (zero_now) begin
      out_source = aoas_pkg::AOAS_OUT_ZERO;
    end else if (plc_err) begin
      out_source = aoas_pkg::AOAS_OUT_ZERO;
    end else if (nvm_keep) begin
      out_source = aoas_pkg::AOAS_OUT_KEEP;
    end else if (num_err) begin
      out_source = aoas_pkg::AOAS_OUT_ZERO;
    end else if (timeout) begin
      out_source = aoas_pkg::AOAS_OUT_KEEP;
    end else if (bus_fault) begin
      out_source = aoas_pkg::AOAS_OUT_HOLD_FN;
    end else if (set_bad) begin
      out_source = aoas_pkg::AOAS_OUT_HOLD_FN;
    end else begin
      out_source = aoas_pkg::AOAS_OUT_LIVE;
    end
  endfunction

  // Value of one channel for a given source
  function automatic logic [WIDTH-1:0] chan_pick(
    input aoas_pkg::aoas_out_sel_t src,
    input logic [WIDTH-1:0]        live,
    input logic [WIDTH-1:0]        hold,
    input logic [WIDTH-1:0]        keep
  );
    unique case (src)
      aoas_pkg::AOAS_OUT_LIVE:    chan_pick = live;
      aoas_pkg::AOAS_OUT_ZERO:    chan_pick = '0;
      aoas_pkg::AOAS_OUT_HOLD_FN: chan_pick = hold;
      aoas_pkg::AOAS_OUT_KEEP:    chan_pick = keep;
    endcase
  endfunction

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  typedef struct packed {
    logic                     run;
    logic                     unit_err;
    logic                     adj_led;
    logic                     host_err;
    logic [15:0]              status;
    logic [15:0]              base;
    logic [NUM_OUT*WIDTH-1:0] aout;
    logic                     hold_err;
    logic                     nvm_err;
    logic                     commit_prev;
    logic                     restart_prev;
    logic                     restarting;
    logic [FW-1:0]            flash_cnt;
    logic [AW-1:0]            rb_addr;
    logic [WIDTH-1:0]         rb_data;
  } aoas_state_t;

  aoas_state_t st;
  aoas_state_t next_st;

  logic [WIDTH-1:0] store_rdata;

  // --------------------------------------------------------------------
  // Channel mirror for read-back
  // --------------------------------------------------------------------
  // Every channel is rewritten once per pass of the walk pointer.
  aoas_out_store #(
    .NUM_OUT (NUM_OUT),
    .WIDTH   (WIDTH)
  ) u_store (
    .clk_i   (clk_i),
    .we_i    (1'b1),
    .waddr_i (st.rb_addr),
    .wdata_i (st.aout[st.rb_addr*WIDTH +: WIDTH]),
    .raddr_i (st.rb_addr),
    .rdata_o (store_rdata)
  );

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  logic                unit_num_bad;
  logic                host_set_err;
  logic                adj_plc_err;
  logic                adj_out_err;
  logic                hold_bad;
  logic [NUM_OUT-1:0]  set_err;
  logic [7:0]          set_err_byte;
  logic                restart_done;
  aoas_pkg::aoas_out_sel_t sel [NUM_OUT];

  always_comb begin
    next_st = st;

    // ------------------------------------------------------------------
    // Fault decode
    // ------------------------------------------------------------------

    unit_num_bad = unit_dup_i || (unit_number_i > aoas_pkg::UNIT_NUM_MAX);
    host_set_err = unit_num_bad || table_mismatch_i;
    adj_plc_err  = adjust_mode_i && host_run_i;
    adj_out_err  = adjust_mode_i && !adj_plc_err &&
                   adj_num_bad(adjust_out_num_i, out_enabled_i);
    hold_bad     = st.hold_err;
    restart_done = st.restart_prev && !restart_i;

    // ------------------------------------------------------------------
    // Base word
    // ------------------------------------------------------------------
    next_st.base = base_word(unit_number_i);

    // ------------------------------------------------------------------
    // Initial-setting flag, cleared only by a restart pulse
    // ------------------------------------------------------------------
    next_st.restart_prev = restart_i;
    next_st.restarting   = restart_i;
    if (restart_done) begin
      next_st.hold_err = hold_setting_i > aoas_pkg::HOLD_CODE_MAX;
    end else if (hold_setting_i > aoas_pkg::HOLD_CODE_MAX) begin
      next_st.hold_err = 1'b1;
    end

    // ------------------------------------------------------------------
    // Memory write error, cleared by commit off-on-off
    // ------------------------------------------------------------------
    next_st.commit_prev = adjust_commit_i;
    if (nvm_fail_i && adjust_mode_i) begin
      next_st.nvm_err = 1'b1;
    end else if (st.commit_prev && !adjust_commit_i) begin
      next_st.nvm_err = 1'b0;
    end else if (!adjust_mode_i) begin
      next_st.nvm_err = 1'b0;
    end

    // ------------------------------------------------------------------
    // Set value errors, tracking their cause directly
    // ------------------------------------------------------------------
    set_err = set_range_err_i;
    if (four_out_i) begin
      for (int i = 4; i < NUM_OUT; i++) begin
        set_err[i] = 1'b0;
      end
    end
    set_err_byte = '0;
    for (int i = 0; i < NUM_OUT && i < aoas_pkg::SET_ERR_WIDTH; i++) begin
      set_err_byte[i] = set_err[i];
    end

    // ------------------------------------------------------------------
    // Status word, written by nothing but this logic
    // ------------------------------------------------------------------
    next_st.status = aoas_pkg::STATUS_RESET;
    if (adj_plc_err) begin
      next_st.status[aoas_pkg::BIT_ADJ_MODE] = 1'b1;
    end else begin
      next_st.status[aoas_pkg::SET_ERR_LSB +: aoas_pkg::SET_ERR_WIDTH] =
        adjust_mode_i ? 8'h00 : set_err_byte;
      next_st.status[aoas_pkg::BIT_HOLD_ERR]   = st.hold_err;
      next_st.status[aoas_pkg::BIT_OUTNUM_ERR] = adj_out_err;
      next_st.status[aoas_pkg::BIT_NVM_ERR]    = st.nvm_err;
      next_st.status[aoas_pkg::BIT_ADJ_MODE]   = adjust_mode_i;
    end

    // ------------------------------------------------------------------
    // Indicators
    // ------------------------------------------------------------------
    next_st.host_err = bus_error_i || host_watchdog_fault_i ||
                       host_set_err;
    next_st.unit_err = hold_bad || st.nvm_err || adj_out_err ||
                       adj_plc_err ||
                       (!adjust_mode_i && |set_err_byte);
    next_st.run = exchange_ok_i && !hold_bad && !unit_num_bad &&
                  !st.restarting;

    // ------------------------------------------------------------------
    // Adjust lamp flash
    // ------------------------------------------------------------------
    if (adjust_mode_i) begin
      if (st.flash_cnt >= FW'(FLASH_CYCLES - 1)) begin
        next_st.flash_cnt = '0;
        next_st.adj_led   = !st.adj_led;
      end else begin
        next_st.flash_cnt = st.flash_cnt + FW'(1);
      end
    end else begin
      next_st.flash_cnt = '0;
      next_st.adj_led   = 1'b0;
    end

    // ------------------------------------------------------------------
    // Output selection
    // ------------------------------------------------------------------
    for (int i = 0; i < NUM_OUT; i++) begin
      sel[i] = out_source(st.restarting || restart_i || unit_num_bad,
                          adj_plc_err,
                          adjust_mode_i && st.nvm_err,
                          adj_out_err,
                          host_timeout_i,
                          bus_error_i || host_watchdog_fault_i,
                          !adjust_mode_i && set_err[i]);
      next_st.aout[i*WIDTH +: WIDTH] =
        chan_pick(sel[i],
                  set_value_i[i*WIDTH +: WIDTH],
                  hold_value_i[i*WIDTH +: WIDTH],
                  st.aout[i*WIDTH +: WIDTH]);
    end

    // ------------------------------------------------------------------
    // Read-back walk over the channels
    // ------------------------------------------------------------------
    if (st.rb_addr == AW'(NUM_OUT - 1)) begin
      next_st.rb_addr = '0;
    end else begin
      next_st.rb_addr = st.rb_addr + AW'(1);
    end
    next_st.rb_data = store_rdata;
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign run_indicator_o        = st.run;
  assign unit_error_indicator_o = st.unit_err;
  assign adjust_indicator_o     = st.adj_led;
  assign host_error_indicator_o = st.host_err;
  assign status_word_o          = st.status;
  assign base_word_o            = st.base;
  assign analog_out_o           = st.aout;
  assign out_readback_o         = st.rb_data;

endmodule // aoas_status

// ### verification/aoas_sva.sv
/*
  Port-level checker for aoas_status.
  Assumes one clock, synchronous active-high reset, 1-cycle answers.
*/
`timescale 1ns/1ps
module aoas_sva #(
  parameter int unsigned NUM_OUT = 8,
  parameter int unsigned WIDTH   = 16
) (
  input wire logic                     clk_i,
  input wire logic                     reset_i,
  input wire logic [6:0]               unit_number_i,
  input wire logic                     unit_dup_i,
  input wire logic                     restart_i,
  input wire logic                     bus_error_i,
  input wire logic                     host_watchdog_fault_i,
  input wire logic                     host_timeout_i,
  input wire logic                     host_run_i,
  input wire logic                     four_out_i,
  input wire logic                     adjust_mode_i,
  input wire logic [NUM_OUT-1:0]       set_range_err_i,
  input wire logic [NUM_OUT*WIDTH-1:0] hold_value_i,
  input wire logic                     unit_error_indicator_o,
  input wire logic                     adjust_indicator_o,
  input wire logic                     host_error_indicator_o,
  input wire logic [15:0]              status_word_o,
  input wire logic [15:0]              base_word_o,
  input wire logic [NUM_OUT*WIDTH-1:0] analog_out_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // Channel 1 out of range with nothing of higher priority pending
  sequence s_hold_case;
    !adjust_mode_i && set_range_err_i[1] && !restart_i && !unit_dup_i &&
    !$past(restart_i) && unit_number_i <= 7'h5f && !host_timeout_i;
  endsequence

  AST_ADJ_FLAG: assert property (adjust_mode_i |=> status_word_o[15])
    else $error("adjust flag missing");
  AST_NORM_FLAG: assert property (!adjust_mode_i |=> !status_word_o[15])
    else $error("adjust flag set in normal mode");
  AST_SET_FLAG: assert property (!adjust_mode_i && set_range_err_i[0]
    |=> status_word_o[0] && unit_error_indicator_o)
    else $error("set value error not flagged");
  AST_SET_CLR: assert property (!set_range_err_i[0] |=> !status_word_o[0])
    else $error("set value flag did not clear");
  AST_FOUR: assert property (four_out_i |=> status_word_o[7:4] == 4'h0)
    else $error("unused flag bits not zero");
  AST_BASE: assert property (!reset_i
    |=> base_word_o == 16'(2000 + 10 * $past(unit_number_i)))
    else $error("base word wrong");
  AST_ADJ_LAMP: assert property (!adjust_mode_i |=> !adjust_indicator_o)
    else $error("adjust lamp lit outside adjust");
  AST_BUS_LAMP: assert property (bus_error_i || host_watchdog_fault_i
    |=> host_error_indicator_o)
    else $error("host error lamp dark");
  AST_HOLD_OUT: assert property (s_hold_case
    |=> analog_out_o[WIDTH+:WIDTH] == $past(hold_value_i[WIDTH+:WIDTH]))
    else $error("output not at hold value");
  AST_STICKY: assert property (status_word_o[10] && !restart_i &&
    !$past(restart_i) && !$past(restart_i, 2) |=> status_word_o[10])
    else $error("hold setting flag cleared without restart");
  AST_PLC_ADJ: assert property (adjust_mode_i && host_run_i
    |=> status_word_o == 16'h8000)
    else $error("status not bit 15 only");
endmodule // aoas_sva

bind aoas_status aoas_sva #(.NUM_OUT(NUM_OUT), .WIDTH(WIDTH)) u_sva (
  .clk_i, .reset_i, .unit_number_i, .unit_dup_i, .restart_i, .bus_error_i,
  .host_watchdog_fault_i, .host_timeout_i, .host_run_i, .four_out_i,
  .adjust_mode_i, .set_range_err_i, .hold_value_i, .unit_error_indicator_o,
  .adjust_indicator_o, .host_error_indicator_o, .status_word_o,
  .base_word_o, .analog_out_o);

// ### verification/aoas_host_model.sv
/*
  Host side model: plays the commit bit retry after a write failure.
  Assumes retry_i is a one-cycle request on clk_i.
*/
`timescale 1ns/1ps
module aoas_host_model (
  input  wire logic clk_i,
  input  wire logic retry_i,
  output logic      commit_o,
  output logic      busy_o
);
  logic [1:0] phase = 2'h0;
  always @(posedge clk_i) begin
    if (retry_i && phase == 2'h0) begin
      phase <= 2'h1;
    end else if (phase != 2'h0) begin
      phase <= phase + 2'h1;
    end
  end
  // Commit bit off, on, off
  assign commit_o = (phase == 2'h2);
  assign busy_o   = (phase != 2'h0);
endmodule // aoas_host_model

// ### verification/tb.sv
/*
  Self-checking bench for aoas_status.
  Assumes a 40 MHz clock and the host model for commit retries.
*/
`timescale 1ns/1ps
module tb;
  logic         clk_i = 1'b0, reset_i = 1'b1;
  logic [6:0]   unit = 7'h05;
  logic         dup = 0, mism = 0, restart = 0, xok = 1, buserr = 0;
  logic         hfault = 0, tmo = 0, run = 0, four = 0, adjust_indicator = 0;
  logic         nvm = 0, retry = 0, commit, busy;
  logic [7:0]   adjnum = 8'h11, en = 8'hff, serr = 8'h00;
  logic [15:0]  hold = 16'h0000, sw, bw, rb;
  logic [127:0] sv, hv, aout;
  logic         run_o, uerr_o, adj_o, herr_o;
  int           n_fail = 0, checked = 0;

  always #12.5 clk_i = ~clk_i;

  aoas_status #(.NUM_OUT(8), .WIDTH(16), .FLASH_CYCLES(4)) DUT (
    .clk_i(clk_i), .reset_i(reset_i), .unit_number_i(unit),
    .unit_dup_i(dup), .table_mismatch_i(mism), .restart_i(restart),
    .exchange_ok_i(xok), .bus_error_i(buserr),
    .host_watchdog_fault_i(hfault), .host_timeout_i(tmo),
    .host_run_i(run), .four_out_i(four), .adjust_mode_i(adjust_indicator),
    .adjust_out_num_i(adjnum), .out_enabled_i(en), .nvm_fail_i(nvm),
    .adjust_commit_i(commit), .hold_setting_i(hold),
    .set_range_err_i(serr), .set_value_i(sv), .hold_value_i(hv),
    .run_indicator_o(run_o), .unit_error_indicator_o(uerr_o),
    .adjust_indicator_o(adj_o), .host_error_indicator_o(herr_o),
    .status_word_o(sw), .base_word_o(bw), .analog_out_o(aout),
    .out_readback_o(rb));

  aoas_host_model host (.clk_i(clk_i), .retry_i(retry),
    .commit_o(commit), .busy_o(busy));

  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  function automatic logic [15:0] ch(input int i);
    return aout[i*16+:16];
  endfunction
  task automatic wait_lamp(input logic v);
    int k;
    k = 0;
    while (adj_o !== v && k < 20) begin tick(1); k++; end
    if (adj_o !== v) begin n_fail++; test_done(); end
  endtask

  task automatic t_set_err;
    @(posedge clk_i) serr <= 8'h27;
    tick(3);
    chk("set flags", sw, 16'h0027);
    chk("unit lamp", uerr_o, 16'h0001);
    chk("ch2 hold", ch(2), 16'h0a02);
    @(posedge clk_i) four <= 1;
    tick(3);
    chk("four flags", sw, 16'h0007);
    @(posedge clk_i) begin serr <= 8'h00; four <= 0; end
    tick(3);
    chk("flags clear", sw, 16'h0000);
    chk("unit lamp off", uerr_o, 16'h0000);
  endtask

  task automatic t_adjust;
    @(posedge clk_i) adjust_indicator <= 1;
    tick(3);
    chk("adj flag", sw, 16'h8000);
    wait_lamp(1'b1);
    wait_lamp(1'b0);
    @(posedge clk_i) begin adjnum <= 8'h12; en <= 8'hfd; end
    tick(3);
    chk("outnum flag", sw, 16'ha000);
    chk("ch1 zero", ch(1), 16'h0000);
    @(posedge clk_i) adjnum <= 8'h15;
    tick(3);
    chk("outnum range", sw, 16'ha000);
    @(posedge clk_i) begin run <= 1; en <= 8'hff; adjnum <= 8'h11; end
    tick(3);
    chk("plc in adj", sw, 16'h8000);
    chk("plc ch0 zero", ch(0), 16'h0000);
    @(posedge clk_i) run <= 0;
    @(posedge clk_i) nvm <= 1;
    @(posedge clk_i) begin nvm <= 0; sv[15:0] <= 16'h0111; end
    tick(3);
    chk("nvm flag", sw, 16'hc000);
    chk("nvm keep", ch(0), 16'h0100);
    @(posedge clk_i) retry <= 1;
    @(posedge clk_i) retry <= 0;
    tick(6);
    chk("retry busy", busy, 16'h0000);
    chk("nvm cleared", sw, 16'h8000);
    chk("nvm live", ch(0), 16'h0111);
    @(posedge clk_i) begin adjust_indicator <= 0; sv[15:0] <= 16'h0100; end
    tick(3);
    chk("normal flag", sw, 16'h0000);
    chk("adj lamp off", adj_o, 16'h0000);
  endtask

  task automatic t_init;
    @(posedge clk_i) begin hold <= 16'h0003; restart <= 1; end
    tick(2);
    chk("restart zero", ch(0), 16'h0000);
    @(posedge clk_i) restart <= 0;
    tick(4);
    chk("hold code", sw, 16'h0400);
    chk("hold unit lamp", uerr_o, 16'h0001);
    chk("hold run dark", run_o, 16'h0000);
    @(posedge clk_i) hold <= 16'h0002;
    tick(4);
    chk("sticky", sw, 16'h0400);
    @(posedge clk_i) restart <= 1;
    @(posedge clk_i) restart <= 0;
    tick(4);
    chk("restart clear", sw, 16'h0000);
    chk("run back", run_o, 16'h0001);
  endtask

  task automatic t_host;
    logic [15:0] acc;
    @(posedge clk_i) buserr <= 1;
    tick(3);
    chk("bus lamp", herr_o, 16'h0001);
    chk("bus hold", ch(0), 16'h0a00);
    // Read-back visits each channel once in eight cycles
    tick(12);
    acc = 16'h0000;
    repeat (8) begin
      acc += rb;
      tick(1);
    end
    chk("readback sum", acc, 16'h501c);
    @(posedge clk_i) begin buserr <= 0; hfault <= 1; end
    tick(3);
    chk("wdt lamp", {run_o, herr_o}, 16'h0003);
    @(posedge clk_i) hfault <= 0;
    tick(3);
    chk("live", ch(0), 16'h0100);
    @(posedge clk_i) begin tmo <= 1; sv[15:0] <= 16'h0155; end
    tick(3);
    chk("timeout keep", ch(0), 16'h0100);
    @(posedge clk_i) begin tmo <= 0; unit <= 7'h60; end
    tick(3);
    chk("bad unit", {run_o, herr_o}, 16'h0001);
    chk("bad unit zero", ch(0), 16'h0000);
    @(posedge clk_i) begin unit <= 7'h05; dup <= 1; end
    tick(3);
    chk("dup unit", {run_o, herr_o}, 16'h0001);
    @(posedge clk_i) begin dup <= 0; mism <= 1; end
    tick(3);
    chk("table", herr_o, 16'h0001);
    @(posedge clk_i) begin mism <= 0; xok <= 0; end
    tick(3);
    chk("no exchange", run_o, 16'h0000);
    @(posedge clk_i) xok <= 1;
    tick(3);
    chk("host lamp off", herr_o, 16'h0000);
    chk("live again", ch(0), 16'h0155);
  endtask

  initial begin
    for (int i = 0; i < 8; i++) begin
      sv[i*16+:16] <= 16'h0100 + 16'(i);
      hv[i*16+:16] <= 16'h0a00 + 16'(i);
    end
    tick(4);
    chk("reset status", sw, 16'h0000);
    @(posedge clk_i) reset_i <= 0;
    tick(3);
    chk("run lamp", run_o, 16'h0001);
    chk("base word", bw, 16'h0802);
    chk("status idle", sw, 16'h0000);
    t_set_err();
    t_adjust();
    t_init();
    t_host();
    test_done();
  end
endmodule // tb
